// *** design/act_conv_timing.sv ***
`timescale 1ns/10ps
// Operation
// RL1: The basic clock is the system clock divided by 4, 2, 16 or 8 for select 00, 01, 10, 11.
// RL2: The sample phase lasts 8, 16, 32 or 64 basic clocks for select 00, 01, 10, 11.
// RL3: A 10-bit conversion takes 52 (or 40 without post-calibration) basic clocks plus sample plus 6 system clocks.
// RL4: An 8-bit conversion takes 44 (or 32 without post-calibration) basic clocks plus sample plus 6 system clocks.
// RL5: A conversion runs sample, then result determination, then a 6-cycle result load.
// RL6: Inputs below ground store zero and inputs above the reference store 3FF.
// RL7: After reset a calibration of 484 to 11696 basic clocks runs, its length set by reference noise.
// RL8: Conversions asked for during calibration are done and stretch the calibration.
// RL9: Software keeps the basic clock between 0.5 MHz and 20 MHz.
// RL10: The table encodings hold in compatibility mode, and an improved clock divider may be chosen.
// RL11: The CPU clock is the master clock or half of it, chosen by one halving bit.
// RL12: The system clock for peripherals runs at the CPU clock rate.
// RL13: A clock generation control field chooses how the master clock is made.
// RL14: A done pulse marks the cycle in which the result register is loaded.
module act_conv_timing #(
  parameter int unsigned CAL_BASE_BC = act_pkg::CAL_MIN_BC,
  parameter int unsigned CAL_MAX     = act_pkg::CAL_MAX_BC
) (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // Software control.
  input  wire act_pkg::act_ctrl_t   ctrl,
  input  wire logic                 start,
  input  wire logic                 cpu_clock_halve,
  input  wire logic [1:0]           clock_gen_control_reg,
  // Analog side, asynchronous to core_clk.
  input  wire act_pkg::act_ain_t    ain,
  input  wire logic                 ref_noise,
  // Status and result.
  output logic                      busy,
  output logic                      cal_busy,
  output logic                      done,
  output logic [9:0]                result,
  output logic                      cpu_clk_en,
  output logic                      sys_clk_en,
  output logic [1:0]                clk_gen_mode
);
  import act_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Basic clock generation.

  logic [7:0] div_sel;
  logic       bc_tick;
  act_state_t state_q;
  act_ctrl_t  cfg_q;
  act_ctrl_t  div_src;

  // A running conversion keeps the divider it started with; idle follows software.
  assign div_src = (state_q == ST_IDLE) ? ctrl : cfg_q;

  // Table divide ratios in compatibility mode or with a zero improved divider, else the direct divider.
  always_comb begin
    if (div_src.improved_clk_mode && div_src.improved_div != 8'h00) begin
      div_sel = div_src.improved_div;                  // see RL10
    end else begin
      case (div_src.conv_clock_select)                 // see RL1
        CKS_DIV4:  div_sel = 8'h04;
        CKS_DIV2:  div_sel = 8'h02;
        CKS_DIV16: div_sel = 8'h10;
        CKS_DIV8:  div_sel = 8'h08;
        default:   div_sel = 8'h04;
      endcase
    end
  end

  // Range of the resulting basic clock is left to software.
  act_pulse_div #(.W(8)) u_bc_div (                    // see RL9
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .div_val  (div_sel),
    .tick     (bc_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the analog comparator lines.

  logic [11:0] ain_s1_q, ain_s2_q, ain_s3_q;
  logic [2:0]  noise_s_q;

  // Three stages; a change counts once the second and third agree.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ain_s1_q  <= '0;
      ain_s2_q  <= '0;
      ain_s3_q  <= '0;
      noise_s_q <= '0;
    end else begin
      ain_s1_q  <= ain;
      ain_s2_q  <= ain_s1_q;
      ain_s3_q  <= ain_s2_q;
      noise_s_q <= {noise_s_q[1:0], ref_noise};
    end
  end

  logic [11:0] ain_q;
  logic        noise_q;

  // Filtered copies taken only when stages two and three match.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ain_q   <= '0;
      noise_q <= 1'b0;
    end else begin
      if (ain_s2_q == ain_s3_q) ain_q <= ain_s3_q;
      if (noise_s_q[1] == noise_s_q[2]) noise_q <= noise_s_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  logic [6:0]  samp_len, conv_len;
  logic [6:0]  bc_cnt_q;
  logic [2:0]  load_cnt_q;
  logic [7:0]  ph_q;
  logic        conv_tick;

  // Sample length doubles per select step.
  assign samp_len = 7'd8 << cfg_q.sample_time_select;  // see RL2

  // The conversion clock restarts its phase at start, so a conversion lasts exactly its
  // table length; the free-running divider would shorten it by up to one basic period.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= 8'h01;
    end else if (state_q == ST_IDLE || conv_tick) begin
      ph_q <= 8'h01;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end

  assign conv_tick = (state_q == ST_SAMPLE || state_q == ST_CONVERT) && (ph_q == div_sel);

  // Determination length by width and post-calibration.
  always_comb begin                                    // see RL3
    case ({cfg_q.res_8bit, cfg_q.post_cal_en})
      2'b01:   conv_len = 7'(BC_10_POST);
      2'b00:   conv_len = 7'(BC_10_RAW);
      2'b11:   conv_len = 7'(BC_8_POST);               // see RL4
      2'b10:   conv_len = 7'(BC_8_RAW);
      default: conv_len = 7'(BC_10_RAW);
    endcase
  end

  // Settings latch at start so a mid-conversion write cannot skew timing.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      cfg_q      <= '0;
      bc_cnt_q   <= '0;
      load_cnt_q <= '0;
    end else begin
      case (state_q)                                   // see RL5
        ST_IDLE: begin
          if (start) begin
            cfg_q    <= ctrl;
            bc_cnt_q <= '0;
            state_q  <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (conv_tick) begin
            if (bc_cnt_q == samp_len - 7'd1) begin
              bc_cnt_q <= '0;
              state_q  <= ST_CONVERT;
            end else begin
              bc_cnt_q <= bc_cnt_q + 7'd1;
            end
          end
        end
        ST_CONVERT: begin
          if (conv_tick) begin
            if (bc_cnt_q == conv_len - 7'd1) begin
              load_cnt_q <= '0;
              state_q    <= ST_LOAD;
            end else begin
              bc_cnt_q <= bc_cnt_q + 7'd1;
            end
          end
        end
        ST_LOAD: begin
          if (load_cnt_q == 3'(LOAD_SYS_CYC - 1)) begin
            state_q <= ST_IDLE;
          end else begin
            load_cnt_q <= load_cnt_q + 3'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic load_end;
  assign load_end = (state_q == ST_LOAD) && (load_cnt_q == 3'(LOAD_SYS_CYC - 1));

  // Result with clamping; 8-bit results keep the upper bits of the code.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= RES_ZERO;
      done   <= 1'b0;
      busy   <= 1'b0;
    end else begin
      done <= load_end;                                // see RL14
      busy <= (state_q != ST_IDLE) && !load_end || (state_q == ST_IDLE && start);
      if (load_end) begin
        if (ain_q[11]) result <= RES_ZERO;             // see RL6
        else if (ain_q[10]) result <= RES_FULL;
        else if (cfg_q.res_8bit) result <= {ain_q[9:2], 2'b00};
        else result <= ain_q[9:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset calibration.

  logic [13:0] cal_cnt_q, cal_len_q;

  // Noise adds basic clocks to the length; conversions stretch it too.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_busy  <= 1'b1;                               // see RL7
      cal_cnt_q <= '0;
      cal_len_q <= 14'(CAL_BASE_BC);
    end else if (cal_busy) begin
      if (state_q != ST_IDLE) begin
        cal_cnt_q <= cal_cnt_q;                        // see RL8
      end else if (bc_tick) begin
        if (cal_cnt_q >= cal_len_q - 14'd1) begin
          cal_busy <= 1'b0;
        end else begin
          cal_cnt_q <= cal_cnt_q + 14'd1;
          if (noise_q && cal_len_q < 14'(CAL_MAX)) cal_len_q <= cal_len_q + 14'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU and system clock enables and clock generation mode.

  logic half_q;

  // The halving bit gates every other master cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_q       <= 1'b0;
      cpu_clk_en   <= 1'b0;
      sys_clk_en   <= 1'b0;
      clk_gen_mode <= 2'h0;
    end else begin
      half_q       <= cpu_clock_halve ? !half_q : 1'b0;
      cpu_clk_en   <= !cpu_clock_halve || half_q;      // see RL11
      sys_clk_en   <= !cpu_clock_halve || half_q;      // see RL12
      clk_gen_mode <= clock_gen_control_reg;           // see RL13
    end
  end

endmodule : act_conv_timing

// *** pkg/act_pkg.sv ***
package act_pkg;

  // Clock and timing figures.
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SYS_NS          = 25;
  localparam int unsigned LOAD_SYS_CYC    = 6;
  localparam int unsigned BC_10_POST      = 52;
  localparam int unsigned BC_10_RAW       = 40;
  localparam int unsigned BC_8_POST       = 44;
  localparam int unsigned BC_8_RAW        = 32;
  localparam int unsigned CAL_MIN_BC      = 484;
  localparam int unsigned CAL_MAX_BC      = 11_696;
  localparam int unsigned BC_MIN_KHZ      = 500;
  localparam int unsigned BC_MAX_KHZ      = 20_000;

  // Result field.
  localparam int unsigned RES_W           = 10;
  localparam logic [9:0]  RES_ZERO        = 10'h000;
  localparam logic [9:0]  RES_FULL        = 10'h3ff;

  // Clock-select encodings.
  localparam logic [1:0]  CKS_DIV4        = 2'h0;
  localparam logic [1:0]  CKS_DIV2        = 2'h1;
  localparam logic [1:0]  CKS_DIV16       = 2'h2;
  localparam logic [1:0]  CKS_DIV8        = 2'h3;

  // Control bundle driven by software.
  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [1:0] sample_time_select;
    logic       improved_clk_mode;
    logic [7:0] improved_div;
    logic       post_cal_en;
    logic       res_8bit;
  } act_ctrl_t;

  // Analog comparator view of the input.
  typedef struct packed {
    logic       below_gnd;
    logic       above_ref;
    logic [9:0] code;
  } act_ain_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_LOAD
  } act_state_t;

endpackage : act_pkg

// *** design/act_pulse_div.sv ***
`timescale 1ns/10ps
// Produces a one-cycle tick every div_val cycles of core_clk.
module act_pulse_div #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Divider setting, one or more.
  input  wire logic [W-1:0] div_val,
  output logic              tick
);

  logic [W-1:0] cnt_q;

  // Free-running down counter; reload keeps the tick period exact.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q <= W'(1)) begin
      cnt_q <= div_val;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q - W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : act_pulse_div

// *** verif/act_conv_timing_checker.sv ***
`timescale 1ns/10ps
module act_conv_timing_checker
  import act_pkg::*;
#(
  parameter int unsigned CAL_BASE_BC = 484,
  parameter int unsigned CAL_MAX     = 11_696
) (
  // Clock and reset.
  input wire logic               core_clk,
  input wire logic               arst_n,
  // Control inputs.
  input wire act_pkg::act_ctrl_t ctrl,
  input wire logic               start,
  input wire logic               cpu_clock_halve,
  input wire logic [1:0]         clock_gen_control_reg,
  input wire act_pkg::act_ain_t  ain,
  input wire logic               ref_noise,
  // Outputs.
  input wire logic               busy,
  input wire logic               cal_busy,
  input wire logic               done,
  input wire logic [9:0]         result,
  input wire logic               cpu_clk_en,
  input wire logic               sys_clk_en,
  input wire logic [1:0]         clk_gen_mode
);
  localparam logic [11:0] MIN_CYC = 12'h028;
  logic [11:0] busy_cnt_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Busy length counter; even the shortest legal setting stays above it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) busy_cnt_q <= 12'h000;
    else if (busy) busy_cnt_q <= busy_cnt_q + 12'h001;
    else busy_cnt_q <= 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol and timing relations at the ports.
  a_done_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_start_busy: assert property (start && !busy |=> busy)
    else $error("start in idle did not raise busy");
  a_min_length: assert property (done |-> busy_cnt_q >= MIN_CYC)
    else $error("conversion shorter than legal minimum");
  a_result_hold: assert property ($changed(result) |-> done)
    else $error("result changed without done");
  a_sys_cpu: assert property (sys_clk_en == cpu_clk_en)
    else $error("system clock enable differs from cpu enable");
  a_halve_toggle: assert property (cpu_clock_halve [*3] |=> $changed(cpu_clk_en))
    else $error("halved cpu enable did not toggle");
  a_full_speed: assert property (!cpu_clock_halve [*2] |=> cpu_clk_en)
    else $error("cpu enable low at full speed");
  a_gen_copy: assert property (1'b1 |=> clk_gen_mode == $past(clock_gen_control_reg))
    else $error("clock generation mode not copied");

  c_done: cover property (done);
  c_cal_end: cover property ($fell(cal_busy));
  c_conv_in_cal: cover property (done && cal_busy);
endmodule : act_conv_timing_checker

bind act_conv_timing act_conv_timing_checker #(
  .CAL_BASE_BC(CAL_BASE_BC), .CAL_MAX(CAL_MAX)
) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .ctrl(ctrl), .start(start),
  .cpu_clock_halve(cpu_clock_halve), .clock_gen_control_reg(clock_gen_control_reg),
  .ain(ain), .ref_noise(ref_noise), .busy(busy), .cal_busy(cal_busy), .done(done),
  .result(result), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
  .clk_gen_mode(clk_gen_mode)
);

// *** verif/tb_act_conv_timing.sv ***
`timescale 1ns/10ps
module tb_act_conv_timing;
  import act_pkg::*;
  logic       core_clk, arst_n, start, cpu_clock_halve, ref_noise;
  logic       busy, cal_busy, done, cpu_clk_en, sys_clk_en;
  logic [1:0] clock_gen_control_reg, clk_gen_mode;
  logic [9:0] result;
  act_ctrl_t  ctrl;
  act_ain_t   ain;
  int         n_fail;
  int         checks;

  // A short calibration keeps the run small; it still outlasts one conversion start.
  act_conv_timing #(.CAL_BASE_BC(16), .CAL_MAX(CAL_MAX_BC)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .ctrl(ctrl), .start(start),
    .cpu_clock_halve(cpu_clock_halve), .clock_gen_control_reg(clock_gen_control_reg),
    .ain(ain), .ref_noise(ref_noise), .busy(busy), .cal_busy(cal_busy), .done(done),
    .result(result), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .clk_gen_mode(clk_gen_mode));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    checks++;
    if (seen !== expd) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask : chk

  // The conversion clock starts with the conversion, so the count is exact.
  function automatic logic [31:0] len_ok(int cyc, int d, int s, int c);
    return 32'(cyc == (s + c) * d + 6);
  endfunction : len_ok

  task automatic run_conv(input act_ctrl_t c, input act_ain_t a, output int cyc);
    @(posedge core_clk);
    ctrl <= c;
    ain  <= a;
    repeat (4) @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    chk(32'(busy), 32'd1);
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1;
      cyc++;
    end while (done !== 1'b1 && cyc < 4000);
    chk(32'(busy), 32'd0);
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_cal;
    int cyc;
    chk(32'(cal_busy), 32'd1);
    run_conv('{CKS_DIV2, 2'h0, 1'b0, 8'h00, 1'b1, 1'b0}, '{1'b0, 1'b0, 10'h155}, cyc);
    chk(32'(cal_busy), 32'd1);
    chk(32'(result), 32'h0000_0155);
    cyc = 0;
    while (cal_busy !== 1'b0 && cyc < 400) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    chk(32'(cal_busy), 32'd0);
  endtask : t_cal

  task automatic t_sel;
    int cyc;
    int divs[4] = '{4, 2, 16, 8};
    for (int i = 0; i < 4; i++) begin
      run_conv('{2'(i), 2'h0, 1'b0, 8'h00, 1'b1, 1'b0}, '{1'b0, 1'b0, 10'h0aa}, cyc);
      chk(len_ok(cyc, divs[i], 8, 52), 32'd1);
      run_conv('{CKS_DIV2, 2'(i), 1'b0, 8'h00, 1'b1, 1'b0}, '{1'b0, 1'b0, 10'h0aa}, cyc);
      chk(len_ok(cyc, 2, 8 << i, 52), 32'd1);
    end
  endtask : t_sel

  task automatic t_modes;
    int cyc;
    int cs[4] = '{40, 32, 52, 44};
    for (int i = 0; i < 4; i++) begin
      run_conv('{CKS_DIV2, 2'h0, 1'b0, 8'h00, i[1], i[0]}, '{1'b0, 1'b0, 10'h2b7}, cyc);
      chk(len_ok(cyc, 2, 8, cs[i]), 32'd1);
      chk(32'(result[9:2]), 32'(10'h2b7 >> 2));
      chk(32'(result[1:0]), 32'(i[0] ? 2'b00 : 2'b11));
    end
    // Improved divider must override the compatibility select.
    run_conv('{CKS_DIV16, 2'h0, 1'b1, 8'h03, 1'b0, 1'b0}, '{1'b0, 1'b0, 10'h2b7}, cyc);
    chk(len_ok(cyc, 3, 8, 40), 32'd1);
  endtask : t_modes

  task automatic t_clamp;
    int cyc;
    act_ain_t in_v[3] = '{'{1'b1, 1'b0, 10'h155}, '{1'b0, 1'b1, 10'h001}, '{1'b1, 1'b1, 10'h200}};
    logic [9:0] exp_v[3] = '{RES_ZERO, RES_FULL, RES_ZERO};
    for (int i = 0; i < 3; i++) begin
      run_conv('{CKS_DIV2, 2'h0, 1'b0, 8'h00, 1'b0, 1'b0}, in_v[i], cyc);
      chk(32'(result), 32'(exp_v[i]));
    end
  endtask : t_clamp

  // Reset again in mid-run; reference noise held for a while must stretch calibration.
  task automatic t_reset_noise;
    int cyc[2];
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(32'({busy, done, cal_busy, result}), 32'h0000_0400);
      @(posedge core_clk);
      arst_n    <= 1'b1;
      ref_noise <= k[0];
      cyc[k] = 0;
      while (cal_busy !== 1'b0 && cyc[k] < 400) begin
        @(posedge core_clk);
        if (cyc[k] == 39) ref_noise <= 1'b0;
        #1;
        cyc[k]++;
      end
    end
    chk(32'(cyc[0]), 32'd32);
    chk(32'(cyc[1] >= cyc[0] + 20), 32'd1);
  endtask : t_reset_noise

  task automatic t_clocks;
    int hi;
    @(posedge core_clk);
    cpu_clock_halve <= 1'b1;
    repeat (4) @(posedge core_clk);
    hi = 0;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      hi += int'(cpu_clk_en === 1'b1);
      chk(32'(sys_clk_en), 32'(cpu_clk_en));
    end
    chk(32'(hi), 32'd4);
    @(posedge core_clk);
    cpu_clock_halve <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(cpu_clk_en), 32'd1);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      clock_gen_control_reg <= 2'(m);
      repeat (2) @(posedge core_clk);
      #1;
      chk(32'(clk_gen_mode), 32'(m));
    end
  endtask : t_clocks

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog.
  initial begin
    {arst_n, start, cpu_clock_halve, ref_noise} = 4'h0;
    clock_gen_control_reg = 2'h0;
    ctrl = '0;
    ain = '0;
    n_fail = 0;
    checks = 0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    t_cal;
    t_sel;
    t_modes;
    t_clamp;
    t_reset_noise;
    t_clocks;
    report_and_stop;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    report_and_stop;
  end
endmodule : tb_act_conv_timing
